//--- tpp_pkg.sv
// Package: offsets, fields, modes and state layout of the 8-bit PWM timer
package tpp_pkg;
   localparam int TPP_ADDR_W = 12;

   // Register byte addresses
   localparam logic [11:0] TPP_OFS_OUT_CTRL = 12'h024;
   localparam logic [11:0] TPP_OFS_CLK_CTRL = 12'h028;
   localparam logic [11:0] TPP_OFS_COUNT = 12'h02C;
   localparam logic [11:0] TPP_OFS_CMP_A = 12'h030;
   localparam logic [11:0] TPP_OFS_CMP_B = 12'h034;
   localparam logic [11:0] TPP_OFS_FLAGS = 12'h038;

   // Field positions
   localparam int TPP_ACT_A_POS = 6;
   localparam int TPP_ACT_B_POS = 4;
   localparam int TPP_MODE_LO_POS = 0;
   localparam int TPP_FORCE_A_BIT = 7;
   localparam int TPP_FORCE_B_BIT = 6;
   localparam int TPP_MODE_TOP_BIT = 3;
   localparam int TPP_CLK_SEL_POS = 0;
   localparam int TPP_WRAP_BIT = 0;

   // Counter landmarks
   localparam logic [7:0] TPP_BOTTOM = 8'h00;
   localparam logic [7:0] TPP_MAX = 8'hFF;
   localparam logic [7:0] TPP_STEP = 8'h01;

   // Timer ticks in one dual-slope period with TOP at MAX
   localparam int TPP_PC_STEPS = 510;

   typedef enum logic [2:0] {
      TPP_NORMAL = 3'h0,
      TPP_PC_FF = 3'h1,
      TPP_CTC = 3'h2,
      TPP_FAST_FF = 3'h3,
      TPP_RSV4 = 3'h4,
      TPP_PC_OCR = 3'h5,
      TPP_RSV6 = 3'h6,
      TPP_FAST_OCR = 3'h7
   } tpp_mode_t;

   typedef enum logic [1:0] {
      TPP_ACT_OFF = 2'h0,
      TPP_ACT_TOGGLE = 2'h1,
      TPP_ACT_CLEAR = 2'h2,
      TPP_ACT_SET = 2'h3
   } tpp_act_t;

   typedef struct packed {
      logic [1:0] act_a;
      logic [1:0] act_b;
      logic [1:0] mode_lo;
      logic mode_top;
      logic [2:0] clk_sel;
      logic [7:0] cnt;
      logic down;
      logic [7:0] ocra_buf;
      logic [7:0] ocrb_buf;
      logic [7:0] ocra;
      logic [7:0] ocrb;
      logic out_a;
      logic out_b;
      logic wrap;
      logic [31:0] rdata;
      logic slverr;
      logic [9:0] h_ticks;
      logic h_clean;
   } tpp_state_t;

   // Every control bit, counter and output resets to zero
   localparam tpp_state_t TPP_STATE_RST = '0;
endpackage

//--- tpp_timer8.sv
// 8-bit timer waveform generator with dual-slope PWM and an APB register slave
`timescale 1ns/100ps
module tpp_timer8 (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [tpp_pkg::TPP_ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_tick_enable,
   output logic [7:0] count_value,
   output logic [2:0] clock_select,
   output logic wave_out_a,
   output logic wave_out_b,
   output logic wave_a_override,
   output logic wave_b_override,
   output logic wrap_flag
);
   import tpp_pkg::*;

   tpp_state_t s_q;
   tpp_state_t s_d;
   tpp_mode_t mode;
   logic pc;
   logic fast;
   logic tick;
   logic setup;
   logic acc_wr;
   logic [7:0] wbyte;
   logic [7:0] top_v;
   logic turn_top;
   logic turn_bot;
   logic fast_wrap;
   logic wrap_ev;
   logic match_a;
   logic match_b;
   logic force_a;
   logic force_b;
   logic [31:0] rd_val;
   logic rd_hit;

   assign mode = tpp_mode_t'({s_q.mode_top, s_q.mode_lo});
   assign pc = (mode == TPP_PC_FF) || (mode == TPP_PC_OCR);
   assign fast = (mode == TPP_FAST_FF) || (mode == TPP_FAST_OCR);
   assign top_v = s_q.mode_top ? s_q.ocra : TPP_MAX;
   // tick comes from the prescaler on pclk, so it is used unsynchronised
   assign tick = timer_tick_enable;
   assign setup = psel & ~penable;
   assign acc_wr = psel & penable & pwrite & pstrb[0];
   assign wbyte = pwdata[7:0];

   assign turn_top = tick & pc & ~s_q.down & (s_q.cnt >= top_v);
   assign turn_bot = tick & pc & s_q.down & (s_q.cnt == TPP_BOTTOM);
   assign fast_wrap = tick & fast & (s_q.cnt == top_v);
   assign wrap_ev = pc ? (tick & s_q.down & (s_q.cnt == TPP_STEP)) :
                    fast ? fast_wrap : (tick & (s_q.cnt == TPP_MAX));
   assign match_a = tick & (s_q.cnt == s_q.ocra);
   assign match_b = tick & (s_q.cnt == s_q.ocrb);
   // Force strobes only act outside the PWM modes
   assign force_a = acc_wr & (paddr == TPP_OFS_CLK_CTRL) & wbyte[TPP_FORCE_A_BIT] & ~pc & ~fast;
   assign force_b = acc_wr & (paddr == TPP_OFS_CLK_CTRL) & wbyte[TPP_FORCE_B_BIT] & ~pc & ~fast;

   // Next level of one wave output; channel B passes tog_ok low
   function automatic logic wave_next(
      input logic cur,
      input tpp_act_t act,
      input logic tog_ok,
      input logic hit,
      input logic frc,
      input logic [7:0] lvl
   );
      logic nxt;
      logic inv;
      logic at_top;
      nxt = cur;
      inv = act[0];
      at_top = (lvl == top_v);
      if (!pc && !fast) begin
         if (hit || frc) begin
            unique case (act)
               TPP_ACT_OFF: nxt = cur;
               TPP_ACT_TOGGLE: nxt = ~cur;
               TPP_ACT_CLEAR: nxt = 1'b0;
               TPP_ACT_SET: nxt = 1'b1;
            endcase
         end
      end else if (act == TPP_ACT_TOGGLE) begin
         if (tog_ok && hit) begin
            nxt = ~cur;
         end
      end else if (act[1]) begin
         if (fast) begin
            // match ignored at TOP, BOTTOM action kept
            if (hit && !at_top) begin
               nxt = inv;
            end
            if (fast_wrap) begin
               nxt = ~inv;
            end
         end else begin
            if (hit && !at_top) begin
               nxt = s_q.down ? ~inv : inv;
            end
            // compare at TOP acts at the turn
            if (turn_top && at_top) begin
               nxt = ~inv;
            end
            // level forced at BOTTOM keeps the period symmetric
            if (turn_bot) begin
               nxt = inv ^ (lvl != TPP_BOTTOM);
            end
         end
      end
      return nxt;
   endfunction

   always_comb begin
      rd_val = '0;
      rd_hit = 1'b1;
      case (paddr)
         TPP_OFS_OUT_CTRL: begin
            rd_val[7:0] = {s_q.act_a, s_q.act_b, 2'h0, s_q.mode_lo};
         end
         TPP_OFS_CLK_CTRL: begin
            // Force strobes always read zero
            rd_val[7:0] = {4'h0, s_q.mode_top, s_q.clk_sel};
         end
         TPP_OFS_COUNT: rd_val[7:0] = s_q.cnt;
         TPP_OFS_CMP_A: rd_val[7:0] = s_q.ocra_buf;
         TPP_OFS_CMP_B: rd_val[7:0] = s_q.ocrb_buf;
         TPP_OFS_FLAGS: rd_val[TPP_WRAP_BIT] = s_q.wrap;
         default: rd_hit = 1'b0;
      endcase
   end

   always_comb begin
      s_d = s_q;
      // Read data is latched in the setup cycle so prdata comes from a flop
      if (setup) begin
         s_d.rdata = rd_val;
         s_d.slverr = ~rd_hit;
      end

      if (tick) begin
         if (pc) begin
            if (!s_q.down) begin
               if (s_q.cnt >= top_v) begin
                  s_d.down = 1'b1;
                  s_d.cnt = (s_q.cnt == TPP_BOTTOM) ? TPP_BOTTOM : s_q.cnt - TPP_STEP;
               end else begin
                  s_d.cnt = s_q.cnt + TPP_STEP;
               end
            end else if (s_q.cnt == TPP_BOTTOM) begin
               s_d.down = 1'b0;
               s_d.cnt = (top_v == TPP_BOTTOM) ? TPP_BOTTOM : TPP_STEP;
            end else begin
               s_d.cnt = s_q.cnt - TPP_STEP;
            end
         end else begin
            s_d.down = 1'b0;
            if ((fast && s_q.cnt == top_v) || (mode == TPP_CTC && s_q.cnt == s_q.ocra)) begin
               s_d.cnt = TPP_BOTTOM;
            end else begin
               s_d.cnt = s_q.cnt + TPP_STEP;
            end
         end
      end

      s_d.out_a = wave_next(s_q.out_a, tpp_act_t'(s_q.act_a), s_q.mode_top,
                            match_a, force_a, s_q.ocra);
      s_d.out_b = wave_next(s_q.out_b, tpp_act_t'(s_q.act_b), 1'b0,
                            match_b, force_b, s_q.ocrb);

      // Software writes; a counter write overrides the tick step
      if (acc_wr) begin
         case (paddr)
            TPP_OFS_OUT_CTRL: begin
               s_d.act_a = wbyte[TPP_ACT_A_POS +: 2];
               s_d.act_b = wbyte[TPP_ACT_B_POS +: 2];
               s_d.mode_lo = wbyte[TPP_MODE_LO_POS +: 2];
            end
            TPP_OFS_CLK_CTRL: begin
               s_d.mode_top = wbyte[TPP_MODE_TOP_BIT];
               s_d.clk_sel = wbyte[TPP_CLK_SEL_POS +: 3];
            end
            TPP_OFS_COUNT: s_d.cnt = wbyte;
            TPP_OFS_CMP_A: s_d.ocra_buf = wbyte;
            TPP_OFS_CMP_B: s_d.ocrb_buf = wbyte;
            TPP_OFS_FLAGS: begin
               if (wbyte[TPP_WRAP_BIT]) begin
                  s_d.wrap = 1'b0;
               end
            end
            default: ;
         endcase
      end

      // a wrap in the clearing cycle still sets the flag
      if (wrap_ev) begin
         s_d.wrap = 1'b1;
      end

      // Compare levels: immediate in non-PWM, at TOP in phase correct, at BOTTOM in fast
      if ((!pc && !fast) || turn_top || fast_wrap) begin
         s_d.ocra = s_d.ocra_buf;
         s_d.ocrb = s_d.ocrb_buf;
      end

      if (tick) begin
         s_d.h_ticks = wrap_ev ? '0 : s_q.h_ticks + 10'h001;
      end
      if (wrap_ev && mode == TPP_PC_FF) begin
         s_d.h_clean = 1'b1;
      end
      if (acc_wr || mode != TPP_PC_FF) begin
         s_d.h_clean = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= TPP_STATE_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // Zero-wait slave: every access phase completes at once
   assign pready = 1'b1;
   assign prdata = s_q.rdata;
   assign pslverr = s_q.slverr;
   assign count_value = s_q.cnt;
   assign clock_select = s_q.clk_sel;
   assign wave_out_a = s_q.out_a;
   assign wave_out_b = s_q.out_b;
   assign wrap_flag = s_q.wrap;
   // pin override; the pin direction is still the port logic's business
   assign wave_a_override = (s_q.act_a != TPP_ACT_OFF) &&
                            !((pc || fast) && s_q.act_a == TPP_ACT_TOGGLE && !s_q.mode_top);
   assign wave_b_override = (s_q.act_b != TPP_ACT_OFF) &&
                            !((pc || fast) && s_q.act_b == TPP_ACT_TOGGLE);

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_pc_count_up: assert property (
      pc && tick && !s_q.down && s_q.cnt < top_v && !acc_wr
      |=> s_q.cnt == $past(s_q.cnt) + TPP_STEP)
      else $error("phase correct up-count step wrong");
   a_pc_top_max: assert property (
      mode == TPP_PC_FF && tick && !s_q.down && s_q.cnt == TPP_MAX && !acc_wr
      |=> s_q.down && s_q.cnt == TPP_MAX - TPP_STEP)
      else $error("mode 1 did not turn at MAX");
   a_pc_top_ocr: assert property (
      mode == TPP_PC_OCR && tick && !s_q.down && s_q.cnt == s_q.ocra && !acc_wr
      |=> s_q.down)
      else $error("mode 5 did not turn at compare A");
   a_top_one_tick: assert property (
      turn_top && s_q.cnt == top_v && top_v != TPP_BOTTOM && !acc_wr
      |=> s_q.down && s_q.cnt == $past(s_q.cnt) - TPP_STEP)
      else $error("TOP value held for more than one tick");
   a_bottom_wrap: assert property (
      pc && tick && s_q.down && s_q.cnt == TPP_STEP && !acc_wr
      |=> s_q.wrap && s_q.cnt == TPP_BOTTOM)
      else $error("wrap flag missing at BOTTOM");
   a_pc_clear_up: assert property (
      pc && s_q.act_a == TPP_ACT_CLEAR && !s_q.down && match_a && s_q.ocra != top_v
      && !acc_wr |=> !wave_out_a)
      else $error("up-count match did not clear");
   a_pc_set_down: assert property (
      pc && s_q.act_a == TPP_ACT_CLEAR && s_q.down && match_a && s_q.ocra != top_v
      && s_q.ocra != TPP_BOTTOM && !acc_wr |=> wave_out_a)
      else $error("down-count match did not set");
   a_toggle_gate: assert property (
      (pc || fast) && s_q.act_a == TPP_ACT_TOGGLE && !s_q.mode_top |-> !wave_a_override)
      else $error("toggle output connected without top bit");
   a_override_b: assert property (
      s_q.act_b != TPP_ACT_OFF && !pc && !fast |-> wave_b_override)
      else $error("channel B not routed to pin");
   a_max_high: assert property (
      turn_top && s_q.act_a == TPP_ACT_CLEAR && s_q.ocra == TPP_MAX && !acc_wr
      |=> wave_out_a)
      else $error("compare at MAX not high");
   a_bottom_level: assert property (
      turn_bot && s_q.act_a == TPP_ACT_SET && s_q.ocra != TPP_BOTTOM && !acc_wr
      |=> !wave_out_a)
      else $error("missing transition at BOTTOM");
   a_tick_hold: assert property (
      !tick && !acc_wr |=> $stable(s_q.cnt) && $stable(wave_out_a) && $stable(s_q.down))
      else $error("state moved without tick");
   a_nonpwm_set: assert property (
      !pc && !fast && s_q.act_a == TPP_ACT_SET && match_a && !acc_wr |=> wave_out_a)
      else $error("non-PWM set on match failed");
   a_fast_bottom: assert property (
      s_q.act_a == TPP_ACT_CLEAR && fast_wrap && !acc_wr
      |=> wave_out_a && s_q.cnt == TPP_BOTTOM)
      else $error("fast PWM not set at BOTTOM");
   a_fast_top_skip: assert property (
      fast && s_q.act_a == TPP_ACT_SET && s_q.ocra == top_v && match_a && !acc_wr
      |=> !wave_out_a)
      else $error("fast PWM match at TOP not ignored");
   a_pc_period: assert property (
      mode == TPP_PC_FF && wrap_ev && s_q.h_clean |-> s_q.h_ticks == 10'(TPP_PC_STEPS - 1))
      else $error("phase correct period not 510 ticks");
   a_reserved_zero: assert property (
      setup && paddr == TPP_OFS_OUT_CTRL |=> prdata[3:2] == 2'h0)
      else $error("reserved control bits read nonzero");
   // Channel B has no toggle in the PWM modes, so only the set and clear slopes are guarded for it
   a_pc_b_up: assert property (
      pc && s_q.act_b == TPP_ACT_SET && !s_q.down && match_b && s_q.ocrb != top_v && !acc_wr
      |=> wave_out_b)
      else $error("channel B up-count match did not set");
   a_pc_b_down: assert property (
      pc && s_q.act_b == TPP_ACT_SET && s_q.down && match_b && s_q.ocrb != top_v
      && s_q.ocrb != TPP_BOTTOM && !acc_wr |=> !wave_out_b)
      else $error("channel B down-count match did not clear");
   a_override_a: assert property (
      s_q.act_a != TPP_ACT_OFF && !pc && !fast |-> wave_a_override)
      else $error("channel A not routed to pin");
   a_min_inv_high: assert property (
      turn_bot && s_q.act_a == TPP_ACT_SET && s_q.ocra == TPP_BOTTOM && !acc_wr
      |=> wave_out_a)
      else $error("inverted output at BOTTOM level not high");
   a_nonpwm_toggle: assert property (
      !pc && !fast && s_q.act_a == TPP_ACT_TOGGLE && match_a && !acc_wr
      |=> wave_out_a != $past(wave_out_a))
      else $error("non-PWM toggle on match failed");
   a_fast_set_match: assert property (
      fast && s_q.act_a == TPP_ACT_SET && match_a && s_q.ocra != top_v && !acc_wr
      |=> wave_out_a)
      else $error("fast PWM set on match failed");
   a_wrap_sticky: assert property (
      s_q.wrap && !(acc_wr && paddr == TPP_OFS_FLAGS) |=> s_q.wrap)
      else $error("wrap flag dropped without a clear");

   c_pc_wrap: cover property (mode == TPP_PC_FF && wrap_ev);
   c_pc_ocr_turn: cover property (mode == TPP_PC_OCR && turn_top);
   c_fast_wrap: cover property (fast_wrap && s_q.act_a == TPP_ACT_SET);
   c_fast_top_skip: cover property (fast && s_q.ocra == top_v && match_a);
   c_flag_clear: cover property (s_q.wrap && acc_wr && paddr == TPP_OFS_FLAGS ##1 !s_q.wrap);
endmodule

//--- tpp_timer8_tb.sv
// Self-checking testbench for the 8-bit PWM timer
`timescale 1ns/100ps
module tpp_timer8_tb;
   import tpp_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [TPP_ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [3:0] pstrb = 4'h0;
   logic timer_tick_enable = 1'b0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [7:0] count_value;
   logic [2:0] clock_select;
   logic wave_out_a;
   logic wave_out_b;
   logic wave_a_override;
   logic wave_b_override;
   logic wrap_flag;
   int fail_count = 0;
   int checks_done = 0;
   logic [31:0] rd;
   logic err;

   always #4 pclk = ~pclk;

   tpp_timer8 dut (
      .pclk(pclk),
      .presetn(presetn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .paddr(paddr),
      .pwdata(pwdata),
      .pstrb(pstrb),
      .prdata(prdata),
      .pready(pready),
      .pslverr(pslverr),
      .timer_tick_enable(timer_tick_enable),
      .count_value(count_value),
      .clock_select(clock_select),
      .wave_out_a(wave_out_a),
      .wave_out_b(wave_out_b),
      .wave_a_override(wave_a_override),
      .wave_b_override(wave_b_override),
      .wrap_flag(wrap_flag)
   );

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic hang();
      fail_count++;
      $display("wait ran out at %0t", $time);
      finish_test();
   endtask

   // One APB transfer; outputs are settled again at the following falling edge
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= 4'hF;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) hang();
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(negedge pclk);
   endtask

   // Returns one step after the counter showed v
   task automatic wait_cnt(input logic [7:0] v);
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (count_value !== v && n < 1200);
      if (count_value !== v) hang();
      @(negedge pclk);
   endtask

   task automatic do_reset();
      @(posedge pclk);
      timer_tick_enable <= 1'b0;
      presetn <= 1'b0;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
   endtask

   task automatic tick_on();
      @(posedge pclk);
      timer_tick_enable <= 1'b1;
   endtask

   task automatic t_regs();
      do_reset();
      apb(1'b0, TPP_OFS_OUT_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b1, TPP_OFS_OUT_CTRL, 32'h0000_00FF);
      apb(1'b0, TPP_OFS_OUT_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_00F3);
      chk({wave_a_override, wave_b_override}, 2'b11);
      apb(1'b1, TPP_OFS_OUT_CTRL, 32'h0000_0010);
      chk({wave_a_override, wave_b_override}, 2'b01);
      apb(1'b1, TPP_OFS_OUT_CTRL, 32'h0000_0040);
      chk({wave_a_override, wave_b_override}, 2'b10);
      apb(1'b1, TPP_OFS_OUT_CTRL, 32'h0000_0041);
      chk(wave_a_override, 1'b0);
      apb(1'b1, TPP_OFS_CLK_CTRL, 32'h0000_000B);
      chk(wave_a_override, 1'b1);
      chk(clock_select, 3'h3);
      apb(1'b0, TPP_OFS_CLK_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_000B);
      apb(1'b0, 12'h100, 32'h0000_0000);
      chk(err, 1'b1);
      chk(rd, 32'h0000_0000);
      $display("test regs done");
   endtask

   task automatic t_pc1();
      int n;
      do_reset();
      apb(1'b1, TPP_OFS_CMP_A, 32'h0000_0080);
      apb(1'b1, TPP_OFS_CMP_B, 32'h0000_0040);
      apb(1'b1, TPP_OFS_OUT_CTRL, 32'h0000_00B1);
      repeat (3) @(negedge pclk);
      chk(count_value, 8'h00);
      tick_on();
      wait_cnt(8'h40);
      chk(wave_out_b, 1'b1);
      wait_cnt(8'h80);
      chk(wave_out_a, 1'b0);
      chk(wrap_flag, 1'b0);
      wait_cnt(8'hFF);
      chk(count_value, 8'hFE);
      wait_cnt(8'h80);
      chk(wave_out_a, 1'b1);
      wait_cnt(8'h40);
      chk(wave_out_b, 1'b0);
      wait_cnt(8'h00);
      chk(wrap_flag, 1'b1);
      chk(count_value, 8'h01);
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (count_value !== 8'h00 && n < 600);
      chk(n + 1, TPP_PC_STEPS);
      $display("test phase correct done");
   endtask

   task automatic t_ext();
      logic [1:0] act [4] = '{2'h2, 2'h2, 2'h3, 2'h3};
      logic [7:0] lvl [4] = '{8'h00, 8'hFF, 8'h00, 8'hFF};
      logic expv [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
      int bad;
      for (int i = 0; i < 4; i++) begin
         do_reset();
         apb(1'b1, TPP_OFS_CMP_A, {24'h0, lvl[i]});
         apb(1'b1, TPP_OFS_OUT_CTRL, {24'h0, act[i], 6'h01});
         tick_on();
         wait_cnt(8'hFF);
         wait_cnt(8'h00);
         bad = 0;
         repeat (TPP_PC_STEPS) begin
            @(negedge pclk);
            if (wave_out_a !== expv[i]) bad++;
         end
         chk(bad, 0);
      end
      $display("test extremes done");
   endtask

   task automatic t_m5();
      logic w;
      int n;
      do_reset();
      apb(1'b1, TPP_OFS_CMP_A, 32'h0000_0040);
      apb(1'b1, TPP_OFS_CLK_CTRL, 32'h0000_0008);
      apb(1'b1, TPP_OFS_OUT_CTRL, 32'h0000_0041);
      tick_on();
      wait_cnt(8'h40);
      chk(count_value, 8'h3F);
      w = wave_out_a;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (count_value !== 8'h40 && n < 600);
      @(negedge pclk);
      chk(n + 1, 32'h0000_0080);
      chk(wave_out_a, !w);
      $display("test top from compare done");
   endtask

   task automatic t_np();
      logic [1:0] code [4] = '{2'h3, 2'h1, 2'h1, 2'h2};
      logic expv [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
      logic [7:0] c;
      do_reset();
      apb(1'b1, TPP_OFS_CMP_A, 32'h0000_0010);
      tick_on();
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, TPP_OFS_OUT_CTRL, {24'h0, code[i], 6'h00});
         wait_cnt(8'h10);
         chk(wave_out_a, expv[i]);
      end
      @(posedge pclk);
      timer_tick_enable <= 1'b0;
      @(negedge pclk);
      c = count_value;
      repeat (5) @(negedge pclk);
      chk(count_value, c);
      apb(1'b1, TPP_OFS_OUT_CTRL, 32'h0000_00C0);
      apb(1'b1, TPP_OFS_CLK_CTRL, 32'h0000_0080);
      chk(wave_out_a, 1'b1);
      apb(1'b0, TPP_OFS_CLK_CTRL, 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      apb(1'b1, TPP_OFS_COUNT, 32'h0000_0077);
      chk(count_value, 8'h77);
      apb(1'b1, TPP_OFS_OUT_CTRL, 32'h0000_0000);
      chk(wave_a_override, 1'b0);
      $display("test non-pwm done");
   endtask

   task automatic t_fast();
      int bad;
      for (int i = 0; i < 2; i++) begin
         do_reset();
         apb(1'b1, TPP_OFS_CMP_A, 32'h0000_0030);
         apb(1'b1, TPP_OFS_OUT_CTRL, {24'h0, 1'b1, i[0], 6'h03});
         tick_on();
         wait_cnt(8'h30);
         chk(wave_out_a, i[0]);
         wait_cnt(8'hFF);
         chk(count_value, 8'h00);
         chk(wave_out_a, !i[0]);
      end
      // Compare at TOP: the set at match is dropped, only the clear at BOTTOM shows
      apb(1'b1, TPP_OFS_CMP_A, 32'h0000_00FF);
      wait_cnt(8'hFF);
      bad = 0;
      repeat (256) begin
         @(negedge pclk);
         if (wave_out_a !== 1'b0) bad++;
      end
      chk(bad, 0);
      $display("test fast pwm done");
   endtask

   initial begin
      do_reset();
      t_regs();
      t_pc1();
      t_ext();
      t_m5();
      t_np();
      t_fast();
      finish_test();
   end
endmodule
